// file: verilog/chan_sel_defs.svh
/*
 * timing counts and channel constants of the serial channel-select loader.
 * assumes a 40 MHz system clock; included by bare name.
 */
`ifndef CHAN_SEL_DEFS_SVH
`define CHAN_SEL_DEFS_SVH
`define CLK_HZ          40000000
`define T_GAP_NS        1000000
`define T_START_NS      25000
`define T_LOW_NS        5000
`define T_HIGH_NS       8000
`define T_SETTLE_NS     1500000
`define CYC_GAP         ((`T_GAP_NS * 40 + 999) / 1000)
`define CYC_START       ((`T_START_NS * 40 + 999) / 1000)
`define CYC_LOW         ((`T_LOW_NS * 40 + 999) / 1000)
`define CYC_HIGH        ((`T_HIGH_NS * 40 + 999) / 1000)
`define CYC_SETTLE      ((`T_SETTLE_NS * 40) / 1000)
`define CHAN_BITS       8
`define CHAN_MAX        8'h64
`define CHAN_DEFAULT    8'h32
`define CHAN_FAIL       8'h00
`define BASE_KHZ        20'hDC5DC
`define STEP_KHZ        20'h000FA
`endif

// file: verilog/chan_sel_pkg.sv
/*
 * types shared by the channel-select loader.
 * assumes chan_sel_defs.svh for the numbers.
 */
package chan_sel_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_LOW   = 3'b011,
    ST_HIGH  = 3'b010,
    ST_END   = 3'b110
  } load_st_t;

  typedef struct packed {
    logic [7:0]  chan;
    logic [19:0] freq_khz;
    logic        serial;
  } chan_out_t;
endpackage : chan_sel_pkg

// file: verilog/pin_sync.sv
/*
 * two flip-flop synchroniser for a bus of external pins.
 * assumes asynchronous active-low reset, clock enable freezes state.
 */
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] q_nxt;

  // stage shift
  always_comb begin
    s1_nxt = ce ? d : s1_r;
    q_nxt  = ce ? s1_r : q;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= s1_nxt;
      q    <= q_nxt;
    end
  end
endmodule : pin_sync

// file: verilog/chan_sel_loader.sv
/*
 * serial / parallel channel-select loader of a transmitter.
 * assumes pins arrive asynchronously and a 40 MHz clk_sys.
 */
`include "chan_sel_defs.svh"
module chan_sel_loader
  import chan_sel_pkg::*;
#(
  parameter int CYC_SETTLE_P = `CYC_SETTLE
) (
  input  wire logic      clk_sys,
  input  wire logic      nrst,
  input  wire logic      ce,
  input  wire logic      mode_strap,
  input  wire logic      channel_select_bit0,
  input  wire logic      serial_clock_pin,
  input  wire logic      serial_data_pin,
  output chan_out_t      chan_o,
  output logic           load_err,
  output logic           chan_valid
);
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // counters lag the seen edge by one cycle: accept the exact minimum
  localparam logic [11:0] C_START = 12'(`CYC_START - 1);
  localparam logic [11:0] C_LOW   = 12'(`CYC_LOW - 1);
  localparam logic [11:0] C_HIGH  = 12'(`CYC_HIGH - 1);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] pins_s;
  pin_sync #(.W(4)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .d       ({mode_strap, serial_data_pin, serial_clock_pin,
                channel_select_bit0}),
    .q       (pins_s)
  );
  logic serial_m;
  logic sclk;
  logic sdat;
  assign serial_m = pins_s[3];
  assign sclk     = pins_s[1];
  assign sdat     = pins_s[2];

  // frequency in kHz for a channel
  function automatic logic [19:0] freq_of(input logic [7:0] c);
    freq_of = `BASE_KHZ + 20'(c) * `STEP_KHZ;
  endfunction : freq_of

  // parallel table entry as a serial channel index
  function automatic logic [7:0] par_chan(input logic [2:0] p);
    unique case (p)
      3'h0: par_chan = 8'h03;
      3'h1: par_chan = 8'h0F;
      3'h2: par_chan = 8'h15;
      3'h3: par_chan = 8'h1B;
      3'h4: par_chan = 8'h27;
      3'h5: par_chan = 8'h33;
      3'h6: par_chan = 8'h45;
      3'h7: par_chan = 8'h4B;
    endcase
  endfunction : par_chan

  // ****************************************************************
  // serial load state machine
  // ****************************************************************
  load_st_t    st_r,   st_nxt;
  logic [11:0] cnt_r,  cnt_nxt;
  logic [7:0]  shf_r,  shf_nxt;
  logic [3:0]  bits_r, bits_nxt;
  logic        sclk_r, sclk_nxt;
  logic [7:0]  chan_r, chan_nxt;
  logic        err_r,  err_nxt;
  logic        init_r, init_nxt;
  logic [20:0] setl_r, setl_nxt;
  logic [1:0]  fill_r, fill_nxt;
  logic        rise;
  logic        fall;

  assign rise = sclk & ~sclk_r;
  assign fall = ~sclk & sclk_r;

  // next state of loader and selected channel
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = (cnt_r == 12'hFFF) ? cnt_r : cnt_r + 12'h001;
    shf_nxt  = shf_r;
    bits_nxt = bits_r;
    sclk_nxt = sclk;
    chan_nxt = chan_r;
    err_nxt  = err_r;
    init_nxt = 1'b1;
    setl_nxt = (setl_r == '0) ? setl_r : setl_r - 21'h000001;
    fill_nxt = (fill_r == 2'h2) ? fill_r : fill_r + 2'h1;
    if (!init_r) begin
      // keep the reset channel until both sync stages hold real pins
      init_nxt = (fill_r == 2'h2);
      if (fill_r == 2'h2) begin
        chan_nxt = serial_m ? `CHAN_DEFAULT : par_chan(pins_s[2:0]);
      end
    end else if (!serial_m) begin
      st_nxt = ST_IDLE;
      if (chan_r != par_chan(pins_s[2:0])) begin
        chan_nxt = par_chan(pins_s[2:0]);
      end
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (sclk && !sdat) begin
            st_nxt  = ST_START;
            cnt_nxt = '0;
          end
        end
        ST_START: begin
          if (fall && !sdat) begin
            st_nxt   = (cnt_r >= C_START) ? ST_LOW : ST_END;
            err_nxt  = (cnt_r < C_START);
            cnt_nxt  = '0;
            bits_nxt = '0;
          end else if (sdat) begin
            st_nxt = ST_IDLE;  // start abandoned
          end
        end
        ST_LOW: begin
          if (rise) begin
            // lsb first shift at the rising edge
            shf_nxt  = {sdat, shf_r[7:1]};
            bits_nxt = bits_r + 4'h1;
            cnt_nxt  = '0;
            st_nxt   = ST_HIGH;
            if (cnt_r < C_LOW) begin
              err_nxt = 1'b1;
            end
          end
        end
        ST_HIGH: begin
          if (fall) begin
            cnt_nxt = '0;
            if (cnt_r < C_HIGH || bits_r == 4'h8) begin
              err_nxt = 1'b1;
              st_nxt  = ST_END;
              chan_nxt = `CHAN_FAIL;
            end else begin
              st_nxt = ST_LOW;
            end
          end else if (bits_r == 4'h8 && sdat) begin
            // both lines high after eighth bit: latch
            st_nxt = ST_END;
            if (err_r || shf_r > `CHAN_MAX) begin
              err_nxt  = 1'b1;
              chan_nxt = `CHAN_FAIL;
            end else begin
              chan_nxt = shf_r;
            end
          end
        end
        ST_END: begin
          if (err_r) begin
            chan_nxt = `CHAN_FAIL;
          end
          if (!sclk || !sdat) begin
            st_nxt = (sclk && !sdat) ? ST_START : ST_IDLE;
            cnt_nxt = '0;
            if (sclk && !sdat) begin
              err_nxt = 1'b0;
            end
          end
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
    if (chan_nxt != chan_r || !init_r) begin
      setl_nxt = 21'(CYC_SETTLE_P);
    end
  end

  // register all loader state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r   <= ST_IDLE;
      cnt_r  <= '0;
      shf_r  <= '0;
      bits_r <= '0;
      sclk_r <= 1'b0;
      chan_r <= `CHAN_DEFAULT;
      err_r  <= 1'b0;
      init_r <= 1'b0;
      setl_r <= '0;
      fill_r <= '0;
    end else if (ce) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      shf_r  <= shf_nxt;
      bits_r <= bits_nxt;
      sclk_r <= sclk_nxt;
      chan_r <= chan_nxt;
      err_r  <= err_nxt;
      init_r <= init_nxt;
      setl_r <= setl_nxt;
      fill_r <= fill_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic [19:0] freq_r;
  logic        ser_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      freq_r <= 20'h0;
      ser_r  <= 1'b0;
    end else if (ce) begin
      freq_r <= freq_of(chan_r);
      ser_r  <= serial_m;
    end
  end
  assign chan_o     = '{chan: chan_r, freq_khz: freq_r, serial: ser_r};
  assign load_err   = err_r;
  assign chan_valid = init_r && (setl_r == '0);

  // ****************************************************************
  // checks
  // ****************************************************************
  a_latch_range: assert property (
    ce && init_r && serial_m && st_r == ST_HIGH && bits_r == 4'h8
    && sdat && !err_r && shf_r <= `CHAN_MAX |=> chan_r == $past(shf_r))
    else $error("valid load not applied");
  a_bad_fallback: assert property (
    ce && init_r && serial_m && st_r == ST_HIGH && bits_r == 4'h8
    && sdat && shf_r > `CHAN_MAX |=> chan_r == 8'h00 && err_r)
    else $error("out of range not channel 0");
  a_short_start: assert property (
    ce && init_r && serial_m && st_r == ST_START && fall && !sdat
    && cnt_r < C_START |=> err_r && st_r == ST_END)
    else $error("short start not flagged");
  a_short_low: assert property (
    ce && init_r && serial_m && st_r == ST_LOW && rise
    && cnt_r < C_LOW |=> err_r)
    else $error("short low not flagged");
  a_short_high: assert property (
    ce && init_r && serial_m && st_r == ST_HIGH && fall
    && cnt_r < C_HIGH |=> chan_r == 8'h00)
    else $error("short high not fallback");
  a_lsb_shift: assert property (
    ce && init_r && serial_m && st_r == ST_LOW && rise
    |=> shf_r[7] == $past(sdat) && st_r == ST_HIGH)
    else $error("bit not shifted in");
  a_powerup_50: assert property (
    ce && !init_r && serial_m |=> chan_r == 8'h32)
    else $error("power-up not channel 50");
  a_freq_map: assert property (
    ce && init_r ##1 ce && $stable(chan_r)
    |-> freq_r == 20'hDC5DC + 20'(chan_r) * 20'h000FA)
    else $error("frequency map wrong");
  a_parallel: assert property (
    ce && init_r && !serial_m |=> chan_r == par_chan($past(pins_s[2:0])))
    else $error("parallel channel wrong");
  a_no_timeout: assert property (
    ce && st_r == ST_LOW && serial_m && !rise && init_r
    |=> st_r == ST_LOW)
    else $error("low phase timed out");

  c_good_load: cover property (
    st_r == ST_HIGH ##1 st_r == ST_END && !err_r);
  c_err_load: cover property (
    st_r == ST_END && err_r);
  c_parallel: cover property (
    init_r && !serial_m && $changed(chan_r));
  c_valid: cover property (
    $rose(chan_valid));
endmodule : chan_sel_loader

// file: sim/ctl_model.sv
/*
 * behavioural controller that bit-bangs the serial channel load.
 * assumes it shares clk_sys with the loader; pins are re-synced there.
 */
module ctl_model (
  input  wire logic clk_sys,
  output logic      serial_clock_pin,
  output logic      serial_data_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // lines idle low until the first load
  initial begin
    serial_clock_pin = 1'b0;
    serial_data_pin  = 1'b0;
  end

  // wait a number of system clock edges
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold

  // drive both pins, also used as parallel code bits
  task automatic set_pins(input logic c, input logic d);
    @(posedge clk_sys);
    serial_clock_pin <= c;
    serial_data_pin  <= d;
  endtask : set_pins

  // one load: start, eight bits lsb first, latch, back to idle
  task automatic load(input logic [7:0] v, input int lo, input int hi);
    set_pins(1'b1, 1'b0);
    hold(1008);
    serial_clock_pin <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      hold(4);
      serial_data_pin <= v[i];
      hold(lo);
      serial_clock_pin <= 1'b1;
      hold(hi);
      if (i < 7) serial_clock_pin <= 1'b0;
    end
    serial_data_pin <= 1'b1;
    hold(16);
    // clock drops first so no false start is seen
    serial_clock_pin <= 1'b0;
    hold(8);
    serial_data_pin <= 1'b0;
  endtask : load
endmodule : ctl_model

// file: sim/tb.sv
/*
 * self-checking bench of the channel-select loader.
 * assumes ctl_model drives the serial pins; 40 MHz clk_sys.
 */
module tb
  import chan_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic      clk_sys;
  logic      nrst;
  logic      ce;
  logic      mode_strap;
  logic      channel_select_bit0;
  wire logic serial_clock_pin;
  wire logic serial_data_pin;
  chan_out_t chan_o;
  logic      load_err;
  logic      chan_valid;
  int        n_mismatch;
  int        n_compared;
  int        exp_chan;
  int        exp_err;
  int        exp_ser;
  int        v;
  int        par_tab [8] = '{3, 15, 21, 27, 39, 51, 69, 75};

  chan_sel_loader #(.CYC_SETTLE_P(20)) i_chan_sel_loader (
    .clk_sys             (clk_sys),
    .nrst                (nrst),
    .ce                  (ce),
    .mode_strap          (mode_strap),
    .channel_select_bit0 (channel_select_bit0),
    .serial_clock_pin    (serial_clock_pin),
    .serial_data_pin     (serial_data_pin),
    .chan_o              (chan_o),
    .load_err            (load_err),
    .chan_valid          (chan_valid)
  );

  ctl_model i_ctl_model (
    .clk_sys          (clk_sys),
    .serial_clock_pin (serial_clock_pin),
    .serial_data_pin  (serial_data_pin)
  );

  // 25 ns system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : check

  // compare channel, frequency, serial flag and load_err against the bench model
  task automatic expect_all();
    logic [31:0] f;
    f = 32'(902620 + 250 * exp_chan);
    check({24'h0, chan_o.chan}, 32'(exp_chan));
    check({12'h0, chan_o.freq_khz}, f);
    check({31'h0, chan_o.serial}, 32'(exp_ser));
    check({31'h0, load_err}, 32'(exp_err));
  endtask : expect_all

  // print counts and verdict, then stop
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // watchdog against a hung sequence
  initial begin
    repeat (99000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  // ***********************************
  // main test sequence
  // ***********************************
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    nrst = 1'b0;
    ce = 1'b1;
    mode_strap = 1'b1;
    channel_select_bit0 = 1'b0;
    void'($urandom(45));
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    exp_chan = 50;
    exp_err = 0;
    exp_ser = 1;
    expect_all();
    repeat (40) @(posedge clk_sys);
    check({31'h0, chan_valid}, 32'h1);
    $display("test power_up done");
    repeat (40000) @(posedge clk_sys);
    v = $urandom_range(100, 0);
    if (v == 50) v = 49;
    i_ctl_model.load(8'(v), 400, 640);
    repeat (10) @(posedge clk_sys);
    exp_chan = v;
    expect_all();
    repeat (40) @(posedge clk_sys);
    check({31'h0, chan_valid}, 32'h1);
    $display("test serial_load done");
    repeat (40000) @(posedge clk_sys);
    v = $urandom_range(255, 101);
    i_ctl_model.load(8'(v), 200, 328);
    repeat (10) @(posedge clk_sys);
    exp_chan = 0;
    exp_err = 1;
    expect_all();
    $display("test bad_value done");
    mode_strap <= 1'b0;
    exp_ser = 0;
    exp_err = 0;
    for (int i = 0; i < 8; i++) begin
      channel_select_bit0 <= i[0];
      i_ctl_model.set_pins(i[1], i[2]);
      repeat (10) @(posedge clk_sys);
      exp_chan = par_tab[i];
      check({24'h0, chan_o.chan}, 32'(exp_chan));
      check({31'h0, chan_o.serial}, 32'h0);
    end
    $display("test parallel done");
    ce <= 1'b0;
    channel_select_bit0 <= 1'b0;
    i_ctl_model.set_pins(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    check({24'h0, chan_o.chan}, 32'(exp_chan));
    ce <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check({24'h0, chan_o.chan}, 32'(par_tab[0]));
    $display("test clock_enable done");
    summarize();
  end
endmodule : tb
